// [aem_pkg.sv]
/*
 * Shared constants, types and helper function for the access control
 * entry matcher: setting encodings and the ARP field values it tests.
 * Assumes a single synchronous clock domain for every user.
 */
package aem_pkg;

    // Frame classes the parser reports and an entry is built for
    typedef enum logic [1:0] {CLS_ARP, CLS_ICMP, CLS_L4} aem_class_t;

    // Three-way check: 0 excludes, 1 requires, any ignores
    typedef enum logic [1:0] {TRI_ZERO, TRI_ONE, TRI_ANY} aem_tri_t;

    // IP address filter settings
    typedef enum logic [1:0] {IPF_ANY, IPF_HOST, IPF_NETWORK} aem_ipf_t;

    // Two-way value filter settings
    typedef enum logic {VAL_ANY, VAL_SPECIFIC} aem_val_t;

    // Port filter settings
    typedef enum logic [1:0] {PORT_ANY, PORT_SPECIFIC, PORT_RANGE}
        aem_port_t;

    // Field widths
    localparam int IP_W   = 32;
    localparam int MAC_W  = 48;
    localparam int PORT_W = 16;

    // ARP field values the length and space checks look for
    localparam logic [7:0]  HLN_ETHERNET = 8'h06;
    localparam logic [7:0]  PLN_IPV4     = 8'h04;
    localparam logic [15:0] HRD_ETHERNET = 16'h0001;
    localparam logic [15:0] PRO_IPV4     = 16'h0800;

    // Cycles from an accepted frame to its verdict
    localparam int VERDICT_LAT = 1;

    // Apply a three-way setting to a condition
    function automatic logic tri_pass(input aem_tri_t sel,
                                      input logic     cond);
        logic res;
        res = 1'b1;
        unique case (sel)
            TRI_ZERO: res = !cond;
            TRI_ONE:  res = cond;
            TRI_ANY:  res = 1'b1;
            default:  res = 1'b0;
        endcase
        return res;
    endfunction : tri_pass

endpackage : aem_pkg

// [aem_port_filter.sv]
/*
 * One TCP/UDP port criterion: any, a single value, or an inclusive
 * range. Purely combinational; the caller registers the verdict.
 * Assumes inputs are stable in the cycle the caller samples pass.
 */
module aem_port_filter #(
    parameter int WIDTH = 16
) (
    input  wire aem_pkg::aem_port_t mode,
    input  wire logic [WIDTH-1:0]   value,
    input  wire logic [WIDTH-1:0]   lower,
    input  wire logic [WIDTH-1:0]   upper,
    input  wire logic [WIDTH-1:0]   port,
    output logic                    pass
);

    ////////////////////////////////////////////////////////////////////
    // Compare the frame port; an inverted range never passes
    always_comb
    begin
        pass = 1'b0;
        unique case (mode)
            aem_pkg::PORT_ANY:      pass = 1'b1;
            aem_pkg::PORT_SPECIFIC: pass = (port == value);
            aem_pkg::PORT_RANGE:    pass = (port >= lower) &&
                                           (port <= upper);
            default:                pass = 1'b0; // Unused code 3
        endcase
    end

endmodule : aem_port_filter

// [aem_entry_matcher.sv]
/*
 * Access control entry matcher for ARP/RARP, ICMP and TCP/UDP frames.
 * The entry's settings are plain level ports; the parser presents one
 * decoded header per frm_valid pulse and the verdict appears on the
 * next edge as a one-cycle match_valid with match_hit beside it.
 * Assumes the parser runs on ref_clk, so no input is synchronised,
 * and that settings are held steady while frames are classified.
 */

// Notes on behaviour
// - With sender filter host, the sender address must equal the set one.
// - With sender filter network, sender address agrees under the mask.
// - With target filter any, the target address is not looked at.
// - With target filter host, the target address must equal the set one.
// - With target filter network, target address agrees under its mask.
// - ARP sender-MAC check: 0 wants SHA differ, 1 equal, any ignores.
// - RARP target-MAC check: 0 wants THA differ, 1 equal, any ignores.
// - Length check: 1 wants HLN 6 and PLN 4, 0 excludes only that pair together, any off.
// - Hardware-space check: 1 wants type 1, 0 excludes it, any off.
// - Protocol-space check: 1 wants 0x800, 0 excludes it, any off.
// - ICMP type filter any or specific; specific wants an equal type.
// - ICMP code filter any or specific; specific wants an equal code.
// - Source port filter is any, specific or range.
// - Specific source port must equal the set 16-bit value.
// - Range source port must lie within the set bounds inclusive.
// - Destination port filter works the same as the source filter.
module aem_entry_matcher (
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    // Entry settings
    input  wire aem_pkg::aem_class_t        entry_class,
    input  wire aem_pkg::aem_ipf_t          sender_ip_criterion,
    input  wire logic [31:0]                sender_ip_addr,
    input  wire logic [31:0]                sender_ip_mask,
    input  wire aem_pkg::aem_ipf_t          target_ip_criterion,
    input  wire logic [31:0]                target_ip_addr,
    input  wire logic [31:0]                target_ip_mask,
    input  wire aem_pkg::aem_tri_t          arp_frame_source_mac_chk,
    input  wire aem_pkg::aem_tri_t          rarp_frame_source_mac_chk,
    input  wire aem_pkg::aem_tri_t          len_chk,
    input  wire aem_pkg::aem_tri_t          hrd_chk,
    input  wire aem_pkg::aem_tri_t          pro_chk,
    input  wire aem_pkg::aem_val_t          icmp_type_mode,
    input  wire logic [7:0]                 icmp_type_val,
    input  wire aem_pkg::aem_val_t          icmp_code_mode,
    input  wire logic [7:0]                 icmp_code_val,
    input  wire aem_pkg::aem_port_t         src_port_mode,
    input  wire logic [15:0]                src_port_val,
    input  wire logic [15:0]                src_port_lo,
    input  wire logic [15:0]                src_port_hi,
    input  wire aem_pkg::aem_port_t         dst_port_mode,
    input  wire logic [15:0]                dst_port_val,
    input  wire logic [15:0]                dst_port_lo,
    input  wire logic [15:0]                dst_port_hi,
    // Decoded frame from the parser
    input  wire logic                       frm_valid,
    input  wire aem_pkg::aem_class_t        frm_class,
    input  wire logic                       frm_is_rarp,
    input  wire logic [47:0]                frame_source_mac,
    input  wire logic [47:0]                frm_sha,
    input  wire logic [47:0]                frm_tha,
    input  wire logic [31:0]                frm_spa,
    input  wire logic [31:0]                frm_tpa,
    input  wire logic [7:0]                 frm_hln,
    input  wire logic [7:0]                 frm_pln,
    input  wire logic [15:0]                frm_hrd,
    input  wire logic [15:0]                frm_pro,
    input  wire logic [7:0]                 frm_icmp_type,
    input  wire logic [7:0]                 frm_icmp_code,
    input  wire logic [15:0]                frm_src_port,
    input  wire logic [15:0]                frm_dst_port,
    // Verdict
    output logic                            match_valid,
    output logic                            match_hit
);

    ////////////////////////////////////////////////////////////////////
    // Criterion verdicts
    logic sender_ok;
    logic target_ok;
    logic arp_frame_source_mac_ok;
    logic rarp_frame_source_mac_ok;
    logic len_ok;
    logic hrd_ok;
    logic pro_ok;
    logic icmp_type_ok;
    logic icmp_code_ok;
    logic src_ok;
    logic dst_ok;
    logic arp_ok;
    logic icmp_ok;
    logic l4_ok;
    logic next_hit;

    ////////////////////////////////////////////////////////////////////
    // Sender protocol address filter
    always_comb
    begin
        sender_ok = 1'b1;
        unique case (sender_ip_criterion)
            aem_pkg::IPF_ANY:     sender_ok = 1'b1;
            aem_pkg::IPF_HOST:    sender_ok =
                (frm_spa == sender_ip_addr);
            aem_pkg::IPF_NETWORK: sender_ok =
                ((frm_spa ^ sender_ip_addr) & sender_ip_mask) == '0;
            default:              sender_ok = 1'b0; // Unused code 3
        endcase
    end

    // Target protocol address filter; any never reads frm_tpa
    always_comb
    begin
        target_ok = 1'b1;
        unique case (target_ip_criterion)
            aem_pkg::IPF_ANY:     target_ok = 1'b1;
            aem_pkg::IPF_HOST:    target_ok =
                (frm_tpa == target_ip_addr);
            aem_pkg::IPF_NETWORK: target_ok =
                ((frm_tpa ^ target_ip_addr) & target_ip_mask) == '0;
            default:              target_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Hardware-address checks; each applies only to its own opcode
    // family so an ARP setting cannot reject a RARP frame and back
    assign arp_frame_source_mac_ok  = frm_is_rarp ||
        aem_pkg::tri_pass(arp_frame_source_mac_chk, frm_sha == frame_source_mac);
    assign rarp_frame_source_mac_ok = !frm_is_rarp ||
        aem_pkg::tri_pass(rarp_frame_source_mac_chk, frm_tha == frame_source_mac);

    // Length and address-space checks
    assign len_ok = aem_pkg::tri_pass(len_chk,
        (frm_hln == aem_pkg::HLN_ETHERNET) &&
        (frm_pln == aem_pkg::PLN_IPV4));
    assign hrd_ok = aem_pkg::tri_pass(hrd_chk,
        frm_hrd == aem_pkg::HRD_ETHERNET);
    assign pro_ok = aem_pkg::tri_pass(pro_chk,
        frm_pro == aem_pkg::PRO_IPV4);

    ////////////////////////////////////////////////////////////////////
    // ICMP type and code filters
    assign icmp_type_ok = (icmp_type_mode == aem_pkg::VAL_ANY) ||
                          (frm_icmp_type == icmp_type_val);
    assign icmp_code_ok = (icmp_code_mode == aem_pkg::VAL_ANY) ||
                          (frm_icmp_code == icmp_code_val);

    ////////////////////////////////////////////////////////////////////
    // Source and destination port filters share one implementation
    aem_port_filter #(
        .WIDTH (aem_pkg::PORT_W)
    ) u_src_filter (
        .mode  (src_port_mode),
        .value (src_port_val),
        .lower (src_port_lo),
        .upper (src_port_hi),
        .port  (frm_src_port),
        .pass  (src_ok)
    );

    aem_port_filter #(
        .WIDTH (aem_pkg::PORT_W)
    ) u_dst_filter (
        .mode  (dst_port_mode),
        .value (dst_port_val),
        .lower (dst_port_lo),
        .upper (dst_port_hi),
        .port  (frm_dst_port),
        .pass  (dst_ok)
    );

    ////////////////////////////////////////////////////////////////////
    // Combine: the frame class must match the entry, then every
    // criterion of that class must pass
    assign arp_ok  = sender_ok && target_ok && arp_frame_source_mac_ok &&
                     rarp_frame_source_mac_ok && len_ok && hrd_ok && pro_ok;
    assign icmp_ok = icmp_type_ok && icmp_code_ok;
    assign l4_ok   = src_ok && dst_ok;

    always_comb
    begin
        next_hit = 1'b0;
        if (frm_class == entry_class)
        begin
            unique case (entry_class)
                aem_pkg::CLS_ARP:  next_hit = arp_ok;
                aem_pkg::CLS_ICMP: next_hit = icmp_ok;
                aem_pkg::CLS_L4:   next_hit = l4_ok;
                default:           next_hit = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Verdict register; hit is cleared between frames so a stale
    // result cannot be mistaken for a new one
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            match_valid <= 1'b0;
            match_hit   <= 1'b0;
        end
        else
        begin
            match_valid <= frm_valid;
            match_hit   <= frm_valid && next_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the verdict against its cause
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sender_host_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        sender_ip_criterion == aem_pkg::IPF_HOST &&
        frm_spa != sender_ip_addr |=> match_valid && !match_hit)
        else $error("sender host mismatch hit");

    sender_net_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        sender_ip_criterion == aem_pkg::IPF_NETWORK &&
        ((frm_spa ^ sender_ip_addr) & sender_ip_mask) != '0
        |=> !match_hit)
        else $error("sender network mismatch hit");

    target_host_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        target_ip_criterion == aem_pkg::IPF_HOST &&
        frm_tpa != target_ip_addr |=> !match_hit)
        else $error("target host mismatch hit");

    target_net_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        target_ip_criterion == aem_pkg::IPF_NETWORK &&
        ((frm_tpa ^ target_ip_addr) & target_ip_mask) != '0
        |=> !match_hit)
        else $error("target network mismatch hit");

    arp_frame_source_mac_a: assert property (
        frm_valid && frm_class == aem_pkg::CLS_ARP && !frm_is_rarp &&
        arp_frame_source_mac_chk == aem_pkg::TRI_ONE && frm_sha != frame_source_mac
        |=> !match_hit)
        else $error("arp frame_source_mac check ignored");

    rarp_frame_source_mac_a: assert property (
        frm_valid && frm_class == aem_pkg::CLS_ARP && frm_is_rarp &&
        rarp_frame_source_mac_chk == aem_pkg::TRI_ZERO && frm_tha == frame_source_mac
        |=> !match_hit)
        else $error("rarp frame_source_mac check ignored");

    len_check_a: assert property (
        frm_valid && len_chk == aem_pkg::TRI_ZERO &&
        frm_hln == aem_pkg::HLN_ETHERNET && frm_pln == aem_pkg::PLN_IPV4 &&
        entry_class == aem_pkg::CLS_ARP |=> !match_hit)
        else $error("length exclusion ignored");

    space_check_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        (pro_chk == aem_pkg::TRI_ONE && frm_pro != aem_pkg::PRO_IPV4 ||
         hrd_chk == aem_pkg::TRI_ONE && frm_hrd != aem_pkg::HRD_ETHERNET)
        |=> !match_hit)
        else $error("address space check ignored");

    icmp_value_a: assert property (
        frm_valid && frm_class == aem_pkg::CLS_ICMP &&
        entry_class == aem_pkg::CLS_ICMP &&
        icmp_type_mode == aem_pkg::VAL_ANY &&
        icmp_code_mode == aem_pkg::VAL_ANY |=> match_valid && match_hit)
        else $error("icmp any did not hit");

    port_range_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_L4 &&
        src_port_mode == aem_pkg::PORT_RANGE &&
        (frm_src_port < src_port_lo || frm_src_port > src_port_hi)
        |=> !match_hit)
        else $error("source port outside range hit");

    hrd_zero_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ARP &&
        hrd_chk == aem_pkg::TRI_ZERO &&
        frm_hrd == aem_pkg::HRD_ETHERNET |=> !match_hit)
        else $error("hardware space exclusion ignored");

    icmp_type_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ICMP &&
        icmp_type_mode == aem_pkg::VAL_SPECIFIC &&
        frm_icmp_type != icmp_type_val |=> !match_hit)
        else $error("icmp type mismatch hit");

    icmp_code_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_ICMP &&
        icmp_code_mode == aem_pkg::VAL_SPECIFIC &&
        frm_icmp_code != icmp_code_val |=> !match_hit)
        else $error("icmp code mismatch hit");

    src_value_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_L4 &&
        src_port_mode == aem_pkg::PORT_SPECIFIC &&
        frm_src_port != src_port_val |=> !match_hit)
        else $error("source port mismatch hit");

    dst_range_a: assert property (
        frm_valid && entry_class == aem_pkg::CLS_L4 &&
        dst_port_mode == aem_pkg::PORT_RANGE &&
        (frm_dst_port < dst_port_lo || frm_dst_port > dst_port_hi)
        |=> !match_hit)
        else $error("destination port outside range hit");

    class_gate_a: assert property (
        frm_valid && frm_class != entry_class
        |=> match_valid && !match_hit)
        else $error("frame of other class hit");

    verdict_pulse_a: assert property (
        match_hit |-> match_valid && $past(frm_valid) &&
        $past(frm_class) == $past(entry_class))
        else $error("hit without matching frame");

endmodule : aem_entry_matcher

// [aem_parser_model.sv]
/*
 * Model of the frame parser feeding the entry matcher.
 * Assumes the caller starts send just after a falling edge of ref_clk.
 */
module aem_parser_model (
    input  wire logic                 ref_clk,
    output logic                      frm_valid,
    output wire aem_pkg::aem_class_t  frm_class,
    output wire logic                 frm_is_rarp,
    output wire logic [47:0]          frame_source_mac,
    output wire logic [47:0]          frm_sha,
    output wire logic [47:0]          frm_tha,
    output wire logic [31:0]          frm_spa,
    output wire logic [31:0]          frm_tpa,
    output wire logic [7:0]           frm_hln,
    output wire logic [7:0]           frm_pln,
    output wire logic [15:0]          frm_hrd,
    output wire logic [15:0]          frm_pro,
    output wire logic [7:0]           frm_icmp_type,
    output wire logic [7:0]           frm_icmp_code,
    output wire logic [15:0]          frm_src_port,
    output wire logic [15:0]          frm_dst_port
);
    timeunit 1ns;
    timeprecision 1ns;

    // Next frame; the bench edits these, defaults pass every criterion except a port range
    aem_pkg::aem_class_t f_class = aem_pkg::CLS_ARP;
    logic                f_rarp = 1'b0;
    logic [47:0]         f_frame_source_mac = 48'h020000000001, f_sha = 48'h020000000001;
    logic [47:0]         f_tha = 48'h020000000001;
    logic [31:0]         f_spa = 32'h0a000001, f_tpa = 32'hc0a80101;
    logic [7:0]          f_hln = 8'h06, f_pln = 8'h04;
    logic [15:0]         f_hrd = 16'h0001, f_pro = 16'h0800;
    logic [7:0]          f_itype = 8'hff, f_icode = 8'h00;
    logic [15:0]         f_sport = 16'hffff, f_dport = 16'hffff;

    initial
    begin
        frm_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outside a pulse the fields are inverted, so stale data never matches
    assign frm_class = frm_valid ? f_class : aem_pkg::aem_class_t'(~f_class);
    assign frm_is_rarp = frm_valid ? f_rarp : ~f_rarp;
    assign frame_source_mac = frm_valid ? f_frame_source_mac : ~f_frame_source_mac;
    assign frm_sha = frm_valid ? f_sha : ~f_sha;
    assign frm_tha = frm_valid ? f_tha : ~f_tha;
    assign frm_spa = frm_valid ? f_spa : ~f_spa;
    assign frm_tpa = frm_valid ? f_tpa : ~f_tpa;
    assign frm_hln = frm_valid ? f_hln : ~f_hln;
    assign frm_pln = frm_valid ? f_pln : ~f_pln;
    assign frm_hrd = frm_valid ? f_hrd : ~f_hrd;
    assign frm_pro = frm_valid ? f_pro : ~f_pro;
    assign frm_icmp_type = frm_valid ? f_itype : ~f_itype;
    assign frm_icmp_code = frm_valid ? f_icode : ~f_icode;
    assign frm_src_port = frm_valid ? f_sport : ~f_sport;
    assign frm_dst_port = frm_valid ? f_dport : ~f_dport;

    // One-cycle frame pulse, falling edge to falling edge
    task send;
        frm_valid = 1'b1;
        @(negedge ref_clk);
        frm_valid = 1'b0;
    endtask : send

endmodule : aem_parser_model

// [aem_entry_matcher_tb.sv]
/*
 * Self-checking bench for the entry matcher.
 * Assumes the parser model drives the frame; settings are bench signals.
 */
module aem_entry_matcher_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                ref_clk = 1'b0;
    logic                rstn = 1'b0;
    aem_pkg::aem_class_t entry_class;
    aem_pkg::aem_ipf_t   sender_ip_criterion, target_ip_criterion;
    aem_pkg::aem_tri_t   arp_frame_source_mac_chk, rarp_frame_source_mac_chk, len_chk;
    aem_pkg::aem_tri_t   hrd_chk, pro_chk;
    aem_pkg::aem_val_t   icmp_type_mode, icmp_code_mode;
    aem_pkg::aem_port_t  src_port_mode, dst_port_mode;
    logic [31:0]         sender_ip_addr = 32'h0a000001;
    logic [31:0]         sender_ip_mask = 32'hffffff00;
    logic [31:0]         target_ip_addr = 32'hc0a80101;
    logic [31:0]         target_ip_mask = 32'hffff0000;
    logic [7:0]          icmp_type_val = 8'hff, icmp_code_val = 8'h00;
    logic [15:0]         src_port_val = 16'hffff, dst_port_val = 16'hffff;
    logic [15:0]         src_port_lo = 16'h0010, src_port_hi = 16'h0020;
    logic [15:0]         dst_port_lo = 16'h0010, dst_port_hi = 16'h0020;
    wire aem_pkg::aem_class_t frm_class;
    wire logic           frm_valid, frm_is_rarp, match_valid, match_hit;
    wire logic [47:0]    frame_source_mac, frm_sha, frm_tha;
    wire logic [31:0]    frm_spa, frm_tpa;
    wire logic [7:0]     frm_hln, frm_pln, frm_icmp_type, frm_icmp_code;
    wire logic [15:0]    frm_hrd, frm_pro, frm_src_port, frm_dst_port;
    int                  error_cnt = 0, checks = 0;

    aem_parser_model pm (.ref_clk, .frm_valid, .frm_class, .frm_is_rarp,
        .frame_source_mac, .frm_sha, .frm_tha, .frm_spa, .frm_tpa, .frm_hln,
        .frm_pln, .frm_hrd, .frm_pro, .frm_icmp_type, .frm_icmp_code,
        .frm_src_port, .frm_dst_port);

    aem_entry_matcher dut (.ref_clk, .rstn, .entry_class,
        .sender_ip_criterion, .sender_ip_addr, .sender_ip_mask,
        .target_ip_criterion, .target_ip_addr, .target_ip_mask, .arp_frame_source_mac_chk,
        .rarp_frame_source_mac_chk, .len_chk, .hrd_chk, .pro_chk, .icmp_type_mode,
        .icmp_type_val, .icmp_code_mode, .icmp_code_val, .src_port_mode,
        .src_port_val, .src_port_lo, .src_port_hi, .dst_port_mode,
        .dst_port_val, .dst_port_lo, .dst_port_hi, .frm_valid, .frm_class,
        .frm_is_rarp, .frame_source_mac, .frm_sha, .frm_tha, .frm_spa, .frm_tpa,
        .frm_hln, .frm_pln, .frm_hrd, .frm_pro, .frm_icmp_type, .frm_icmp_code,
        .frm_src_port, .frm_dst_port, .match_valid, .match_hit);

    // 50 MHz
    always #10 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Verdict stands in the cycle right after the frame and only then;
    // the idle cycle also keeps valid from being raised twice at once
    task go(input logic exp);
        pm.send();
        chk(match_valid, 1'b1);
        chk(match_hit, exp);
        @(negedge ref_clk);
        chk(match_valid, 1'b0);
        chk(match_hit, 1'b0);
    endtask : go

    // All criteria back to don't-care on an ARP entry
    task base;
        entry_class = aem_pkg::CLS_ARP;
        sender_ip_criterion = aem_pkg::IPF_ANY;
        target_ip_criterion = aem_pkg::IPF_ANY;
        arp_frame_source_mac_chk = aem_pkg::TRI_ANY;
        rarp_frame_source_mac_chk = aem_pkg::TRI_ANY;
        len_chk = aem_pkg::TRI_ANY;
        hrd_chk = aem_pkg::TRI_ANY;
        pro_chk = aem_pkg::TRI_ANY;
        icmp_type_mode = aem_pkg::VAL_ANY;
        icmp_code_mode = aem_pkg::VAL_ANY;
        src_port_mode = aem_pkg::PORT_ANY;
        dst_port_mode = aem_pkg::PORT_ANY;
    endtask : base

    ////////////////////////////////////////////////////////////////////////
    task t_ip;
        base();
        sender_ip_criterion = aem_pkg::IPF_HOST;
        go(1'b1);
        pm.f_spa = 32'h0a000003;
        go(1'b0);
        sender_ip_criterion = aem_pkg::IPF_NETWORK;
        go(1'b1);
        pm.f_spa = 32'h0a000101;
        go(1'b0);
        base();
        pm.f_tpa = 32'hc0a8ffff;
        go(1'b1);
        target_ip_criterion = aem_pkg::IPF_NETWORK;
        go(1'b1);
        target_ip_criterion = aem_pkg::IPF_HOST;
        go(1'b0);
        pm.f_tpa = 32'hc0a90101;
        target_ip_criterion = aem_pkg::IPF_NETWORK;
        go(1'b0);
        pm.f_tpa = 32'hc0a80101;
        target_ip_criterion = aem_pkg::IPF_HOST;
        go(1'b1);
        pm.f_spa = 32'h0a000001;
        $display("t_ip done");
    endtask : t_ip

    // Every three-way check, each setting, condition true and false
    task t_tri;
        for (int f = 0; f < 5; f++)
            for (int i = 0; i < 3; i++)
                for (int e = 0; e < 2; e++)
                begin
                    base();
                    pm.f_rarp = (f == 1);
                    case (f)
                        0: arp_frame_source_mac_chk = aem_pkg::aem_tri_t'(i);
                        1: rarp_frame_source_mac_chk = aem_pkg::aem_tri_t'(i);
                        2: len_chk = aem_pkg::aem_tri_t'(i);
                        3: hrd_chk = aem_pkg::aem_tri_t'(i);
                        default: pro_chk = aem_pkg::aem_tri_t'(i);
                    endcase
                    pm.f_sha = pm.f_frame_source_mac ^ {47'h0, e == 0};
                    pm.f_tha = pm.f_frame_source_mac ^ {47'h0, e == 0};
                    pm.f_hln = (e == 1) ? 8'h06 : 8'h05;
                    pm.f_hrd = (e == 1) ? 16'h0001 : 16'h0006;
                    pm.f_pro = (e == 1) ? 16'h0800 : 16'h86dd;
                    go(i == 2 || ((i == 1) == (e == 1)));
                end
        $display("t_tri done");
    endtask : t_tri

    // Two frames on consecutive cycles get their own verdicts
    task t_b2b;
        base();
        sender_ip_criterion = aem_pkg::IPF_HOST;
        pm.frm_valid = 1'b1;
        @(negedge ref_clk);
        pm.f_spa = 32'h0a000009;
        chk(match_valid, 1'b1);
        chk(match_hit, 1'b1);
        @(negedge ref_clk);
        pm.frm_valid = 1'b0;
        chk(match_valid, 1'b1);
        chk(match_hit, 1'b0);
        @(negedge ref_clk);
        chk(match_valid, 1'b0);
        pm.f_spa = 32'h0a000001;
        $display("t_b2b done");
    endtask : t_b2b

    // A frame during a mid-run reset is dropped
    task t_rst;
        rstn = 1'b0;
        pm.send();
        chk(match_valid, 1'b0);
        @(negedge ref_clk);
        rstn = 1'b1;
        chk(match_valid, 1'b0);
        go(1'b1);
        $display("t_rst done");
    endtask : t_rst

    task t_icmp;
        base();
        entry_class = aem_pkg::CLS_ICMP;
        go(1'b0);
        pm.f_class = aem_pkg::CLS_ICMP;
        pm.f_itype = 8'hfe;
        pm.f_icode = 8'h01;
        go(1'b1);
        icmp_code_mode = aem_pkg::VAL_SPECIFIC;
        go(1'b0);
        pm.f_icode = 8'h00;
        go(1'b1);
        icmp_type_mode = aem_pkg::VAL_SPECIFIC;
        go(1'b0);
        pm.f_itype = 8'hff;
        go(1'b1);
        $display("t_icmp done");
    endtask : t_icmp

    // One port case on the source (s=0) or destination (s=1) side
    task pc(input logic s, input aem_pkg::aem_port_t m,
            input logic [15:0] p, input logic exp);
        src_port_mode = s ? aem_pkg::PORT_ANY : m;
        dst_port_mode = s ? m : aem_pkg::PORT_ANY;
        pm.f_sport = s ? 16'h5555 : p;
        pm.f_dport = s ? p : 16'h5555;
        go(exp);
    endtask : pc

    task t_port;
        base();
        entry_class = aem_pkg::CLS_L4;
        pm.f_class = aem_pkg::CLS_L4;
        for (int s = 0; s < 2; s++)
        begin
            pc(s[0], aem_pkg::PORT_SPECIFIC, 16'hffff, 1'b1);
            pc(s[0], aem_pkg::PORT_SPECIFIC, 16'hfffe, 1'b0);
            pc(s[0], aem_pkg::PORT_RANGE, 16'h0010, 1'b1);
            pc(s[0], aem_pkg::PORT_RANGE, 16'h0020, 1'b1);
            pc(s[0], aem_pkg::PORT_RANGE, 16'h000f, 1'b0);
            pc(s[0], aem_pkg::PORT_RANGE, 16'h0021, 1'b0);
            pc(s[0], aem_pkg::PORT_ANY, 16'h1234, 1'b1);
        end
        $display("t_port done");
    endtask : t_port

    task finish_test;
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        base();
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        chk(match_valid, 1'b0);
        t_ip();
        t_tri();
        t_b2b();
        t_rst();
        t_icmp();
        t_port();
        finish_test();
    end

endmodule : aem_entry_matcher_tb
